// >>> src/tia4_regs.sv
`include "tia4_params.svh"

// Functional notes
// RULE1 - upper nibble of swing/rate register trims bandwidth; zero is default
// RULE2 - lower nibble of swing/rate register holds the swing code, read/write
// RULE3 - writing 0110 to the swing code selects the 300 mVpp level
// RULE4 - threshold/gain bit 7 set powers down channel four
// RULE5 - threshold/gain bit 6 set switches off the output buffer
// RULE6 - gain field: 00 default, 10 medium, 11 minimum
// RULE7 - host never writes gain code 01, it is reserved
// RULE8 - threshold nibble is sign-magnitude shift; 0000 and 1000 mean none
// RULE9 - threshold/gain register at 14h, resets to zero, all fields read/write
// RULE10 - swing/rate register fields read/write, clear to zero at reset
// RULE11 - select pad high: settings come from the registers, pads ignored
// RULE12 - swing/rate register sits at address 13h
// RULE13 - select pad low: settings come from the control pads
module tia4_regs
	import tia4_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              core_clk_in,
	input  wire logic              resetn_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	input  wire logic [ADDR_W-1:0] reg_addr_in,
	input  wire logic [7:0]        reg_wdata_in,
	output logic      [7:0]        reg_rdata_out,
	output logic                   reg_rvalid_out,
	input  wire logic              two_wire_select_pad_in,
	input  wire logic              swing_select_pad_in,
	input  wire logic              rate_select_pad_in,
	input  wire logic              gain_select_pad_in,
	input  wire logic              threshold_select_pad_in,
	output logic      [3:0]        bw_trim_code_out,
	output logic      [3:0]        swing_code_out,
	output logic                   power_down_out,
	output logic                   buffer_off_out,
	output tia4_gain_t             gain_step_out,
	output logic                   gain_code_reserved_out,
	output logic      [2:0]        crosspoint_shift_mag_out,
	output logic                   crosspoint_shift_neg_out
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
		$error("tia4_regs: ADDR_W must be 5 to 8");
	end

	localparam logic [ADDR_W-1:0] ADDR_SWING = ADDR_W'(`TIA4_ADDR_SWING_RATE);
	localparam logic [ADDR_W-1:0] ADDR_THG   = ADDR_W'(`TIA4_ADDR_THR_GAIN);

	// ----------------------------------------------------------------
	// field decoder
	// ----------------------------------------------------------------
	tia4_ctrl_if ctrl ();

	tia4_decode u_decode (
		.ctrl (ctrl.dec)
	);

	// ----------------------------------------------------------------
	// register bank state
	// ----------------------------------------------------------------
	logic [7:0] swing_rate_r;
	logic [7:0] swing_rate_nxt;
	logic [7:0] thr_gain_r;
	logic [7:0] thr_gain_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       rvalid_r;
	logic       rvalid_nxt;
	logic       hit_swing;
	logic       hit_thg;

	assign ctrl.thr_gain  = thr_gain_r;
	assign hit_swing      = (reg_addr_in == ADDR_SWING); // RULE12
	assign hit_thg        = (reg_addr_in == ADDR_THG); // RULE9
	assign reg_rdata_out  = rdata_r;
	assign reg_rvalid_out = rvalid_r;

	// write and read-back next values; reads see the value before a same-cycle write
	always_comb begin
		swing_rate_nxt = swing_rate_r;
		thr_gain_nxt   = thr_gain_r;
		rdata_nxt      = rdata_r;
		rvalid_nxt     = reg_rd_in;
		if (reg_wr_in && hit_swing) begin
			swing_rate_nxt = reg_wdata_in; // RULE2
		end
		if (reg_wr_in && hit_thg) begin
			thr_gain_nxt = reg_wdata_in; // RULE9
		end
		if (reg_rd_in) begin
			if (hit_swing) begin
				rdata_nxt = swing_rate_r; // RULE10
			end else if (hit_thg) begin
				rdata_nxt = thr_gain_r; // RULE9
			end else begin
				rdata_nxt = `TIA4_UNMAPPED_DATA;
			end
		end
	end

	// register bank flops, all clear at reset
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			swing_rate_r <= `TIA4_REG_RESET; // RULE10
			thr_gain_r   <= `TIA4_REG_RESET; // RULE9
			rdata_r      <= `TIA4_REG_RESET;
			rvalid_r     <= 1'b0;
		end else begin
			swing_rate_r <= swing_rate_nxt;
			thr_gain_r   <= thr_gain_nxt;
			rdata_r      <= rdata_nxt;
			rvalid_r     <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// applied channel settings
	// ----------------------------------------------------------------
	logic [3:0] bw_r;
	logic [3:0] bw_nxt;
	logic [3:0] swing_r;
	logic [3:0] swing_nxt;
	logic       down_r;
	logic       down_nxt;
	logic       mute_r;
	logic       mute_nxt;
	tia4_gain_t gain_r;
	tia4_gain_t gain_nxt;
	logic       rsvd_r;
	logic       rsvd_nxt;
	logic [2:0] mag_r;
	logic [2:0] mag_nxt;
	logic       neg_r;
	logic       neg_nxt;

	// register control or pad control, picked by the select pad
	always_comb begin
		if (two_wire_select_pad_in) begin
			bw_nxt    = swing_rate_r[`TIA4_RATE_HI:`TIA4_RATE_LO]; // RULE1 RULE11
			swing_nxt = swing_rate_r[`TIA4_SWING_HI:`TIA4_SWING_LO]; // RULE2 RULE3
			down_nxt  = ctrl.power_down; // RULE4
			mute_nxt  = ctrl.buffer_off; // RULE5
			gain_nxt  = ctrl.gain; // RULE6
			rsvd_nxt  = ctrl.gain_reserved;
			mag_nxt   = ctrl.shift_mag; // RULE8
			neg_nxt   = ctrl.shift_neg; // RULE8
		end else begin
			// pads drive rate, swing, gain and shift size; power down, mute, reserved flag and sign held low
			bw_nxt    = rate_select_pad_in ? `TIA4_PAD_RATE_HI : `TIA4_PAD_RATE_LO; // RULE13
			swing_nxt = swing_select_pad_in ? `TIA4_PAD_SWING_HI
				: `TIA4_PAD_SWING_LO; // RULE13
			down_nxt  = 1'b0;
			mute_nxt  = 1'b0;
			gain_nxt  = gain_select_pad_in ? TIA4_GAIN_MEDIUM : TIA4_GAIN_DEFAULT; // RULE13
			rsvd_nxt  = 1'b0;
			mag_nxt   = threshold_select_pad_in ? `TIA4_SHIFT_ONE : `TIA4_SHIFT_ZERO; // RULE13
			neg_nxt   = 1'b0;
		end
	end

	// applied settings flops
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			bw_r    <= `TIA4_RATE_DEFAULT;
			swing_r <= `TIA4_SWING_DEFAULT;
			down_r  <= 1'b0;
			mute_r  <= 1'b0;
			gain_r  <= TIA4_GAIN_DEFAULT;
			rsvd_r  <= 1'b0;
			mag_r   <= `TIA4_SHIFT_ZERO;
			neg_r   <= 1'b0;
		end else begin
			bw_r    <= bw_nxt;
			swing_r <= swing_nxt;
			down_r  <= down_nxt;
			mute_r  <= mute_nxt;
			gain_r  <= gain_nxt;
			rsvd_r  <= rsvd_nxt;
			mag_r   <= mag_nxt;
			neg_r   <= neg_nxt;
		end
	end

	assign bw_trim_code_out         = bw_r;
	assign swing_code_out           = swing_r;
	assign power_down_out           = down_r;
	assign buffer_off_out           = mute_r;
	assign gain_step_out            = gain_r;
	assign gain_code_reserved_out   = rsvd_r;
	assign crosspoint_shift_mag_out = mag_r;
	assign crosspoint_shift_neg_out = neg_r;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!resetn_in);

	AST_WR_SWING_RATE: assert property ( // RULE12
		reg_wr_in && hit_swing |=> swing_rate_r == $past(reg_wdata_in))
		else $error("swing/rate write not stored");
	AST_WR_THR_GAIN: assert property ( // RULE9
		reg_wr_in && hit_thg |=> thr_gain_r == $past(reg_wdata_in))
		else $error("threshold/gain write not stored");
	AST_READBACK: assert property ( // RULE10
		reg_wr_in && hit_swing ##1 reg_rd_in && hit_swing && !reg_wr_in
		|=> reg_rvalid_out && reg_rdata_out == $past(reg_wdata_in, 2))
		else $error("swing/rate read-back mismatch");
	AST_RD_OLD: assert property ( // RULE10
		reg_rd_in && reg_wr_in && hit_swing |=> reg_rdata_out == $past(swing_rate_r))
		else $error("same-cycle read did not return the old value");
	AST_UNMAPPED: assert property (
		reg_rd_in && !hit_swing && !hit_thg
		|=> reg_rvalid_out && reg_rdata_out == `TIA4_UNMAPPED_DATA)
		else $error("unmapped read not zero");
	AST_POWER_DOWN: assert property ( // RULE4
		two_wire_select_pad_in && thr_gain_r[`TIA4_POWER_DOWN_BIT] |=> power_down_out)
		else $error("power down not applied");
	AST_BUFFER_OFF: assert property ( // RULE5
		two_wire_select_pad_in && !thr_gain_r[`TIA4_BUFFER_OFF_BIT] |=> !buffer_off_out)
		else $error("buffer off without its bit");
	AST_GAIN_MIN: assert property ( // RULE6
		two_wire_select_pad_in
		&& thr_gain_r[`TIA4_GAIN_HI:`TIA4_GAIN_LO] == `TIA4_GAIN_CODE_MIN
		|=> gain_step_out == TIA4_GAIN_MINIMUM)
		else $error("minimum gain not decoded");
	AST_ZERO_SHIFT: assert property ( // RULE8
		two_wire_select_pad_in
		&& thr_gain_r[`TIA4_SHIFT_HI:`TIA4_SHIFT_LO] == {1'b1, `TIA4_SHIFT_ZERO}
		|=> crosspoint_shift_mag_out == `TIA4_SHIFT_ZERO && !crosspoint_shift_neg_out)
		else $error("code 1000 must give no shift");
	AST_SWING_300MV: assert property ( // RULE3
		reg_wr_in && hit_swing
		&& reg_wdata_in[`TIA4_SWING_HI:`TIA4_SWING_LO] == `TIA4_SWING_300MV
		##1 two_wire_select_pad_in && !reg_wr_in
		|=> swing_code_out == `TIA4_SWING_300MV)
		else $error("300 mVpp swing code not applied");
	AST_BW_TRIM: assert property ( // RULE1
		two_wire_select_pad_in
		|=> bw_trim_code_out == $past(swing_rate_r[`TIA4_RATE_HI:`TIA4_RATE_LO]))
		else $error("bandwidth trim not taken from register");
	AST_PAD_MODE: assert property ( // RULE13
		!two_wire_select_pad_in && thr_gain_r[`TIA4_POWER_DOWN_BIT]
		|=> !power_down_out && swing_code_out
		== ($past(swing_select_pad_in) ? `TIA4_PAD_SWING_HI : `TIA4_PAD_SWING_LO))
		else $error("pad mode leaked register settings");

endmodule : tia4_regs

// >>> src/tia4_params.svh
`ifndef TIA4_PARAMS_SVH
`define TIA4_PARAMS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TIA4_ADDR_SWING_RATE 8'h13
`define TIA4_ADDR_THR_GAIN   8'h14
`define TIA4_REG_RESET       8'h00
`define TIA4_UNMAPPED_DATA   8'h00

// ----------------------------------------------------------------
// swing/rate fields
// ----------------------------------------------------------------
`define TIA4_RATE_HI         7
`define TIA4_RATE_LO         4
`define TIA4_SWING_HI        3
`define TIA4_SWING_LO        0
`define TIA4_SWING_300MV     4'h6
`define TIA4_RATE_DEFAULT    4'h0
`define TIA4_SWING_DEFAULT   4'h0

// ----------------------------------------------------------------
// threshold/gain fields
// ----------------------------------------------------------------
`define TIA4_POWER_DOWN_BIT  7
`define TIA4_BUFFER_OFF_BIT  6
`define TIA4_GAIN_HI         5
`define TIA4_GAIN_LO         4
`define TIA4_SHIFT_HI        3
`define TIA4_SHIFT_LO        0
`define TIA4_SHIFT_SIGN_BIT  3
`define TIA4_SHIFT_MAG_HI    2
`define TIA4_GAIN_CODE_DEF   2'h0
`define TIA4_GAIN_CODE_RSVD  2'h1
`define TIA4_GAIN_CODE_MED   2'h2
`define TIA4_GAIN_CODE_MIN   2'h3
`define TIA4_SHIFT_ZERO      3'h0
`define TIA4_SHIFT_ONE       3'h1

// ----------------------------------------------------------------
// pad-mode settings
// ----------------------------------------------------------------
`define TIA4_PAD_SWING_HI    4'h6
`define TIA4_PAD_SWING_LO    4'h3
`define TIA4_PAD_RATE_HI     4'hf
`define TIA4_PAD_RATE_LO     4'h0

`endif

// >>> src/tia4_pkg.sv
package tia4_pkg;

	// ----------------------------------------------------------------
	// gain step, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TIA4_GAIN_DEFAULT = 3'h1,
		TIA4_GAIN_MEDIUM  = 3'h2,
		TIA4_GAIN_MINIMUM = 3'h4
	} tia4_gain_t;

endpackage : tia4_pkg

// >>> src/tia4_ctrl_if.sv
// threshold/gain byte out, decoded fields back
interface tia4_ctrl_if;
	import tia4_pkg::*;

	logic [7:0] thr_gain;
	logic       power_down;
	logic       buffer_off;
	tia4_gain_t gain;
	logic       gain_reserved;
	logic [2:0] shift_mag;
	logic       shift_neg;

	modport src (output thr_gain, input power_down, buffer_off, gain, gain_reserved,
		shift_mag, shift_neg);
	modport dec (input thr_gain, output power_down, buffer_off, gain, gain_reserved,
		shift_mag, shift_neg);

endinterface : tia4_ctrl_if

// >>> src/tia4_decode.sv
`include "tia4_params.svh"

// splits the threshold/gain byte into its controls
module tia4_decode
	import tia4_pkg::*;
(
	tia4_ctrl_if.dec ctrl
);

	// ----------------------------------------------------------------
	// field decode
	// ----------------------------------------------------------------
	logic [1:0] gain_code;
	logic [3:0] shift_code;

	always_comb begin
		gain_code          = ctrl.thr_gain[`TIA4_GAIN_HI:`TIA4_GAIN_LO];
		shift_code         = ctrl.thr_gain[`TIA4_SHIFT_HI:`TIA4_SHIFT_LO];
		ctrl.power_down    = ctrl.thr_gain[`TIA4_POWER_DOWN_BIT]; // RULE4
		ctrl.buffer_off    = ctrl.thr_gain[`TIA4_BUFFER_OFF_BIT]; // RULE5
		ctrl.gain_reserved = (gain_code == `TIA4_GAIN_CODE_RSVD);
		// reserved code falls back to default gain
		case (gain_code)
			`TIA4_GAIN_CODE_MED: begin
				ctrl.gain = TIA4_GAIN_MEDIUM; // RULE6
			end
			`TIA4_GAIN_CODE_MIN: begin
				ctrl.gain = TIA4_GAIN_MINIMUM; // RULE6
			end
			default: begin
				ctrl.gain = TIA4_GAIN_DEFAULT; // RULE6
			end
		endcase
		// sign-magnitude shift; both zero codes give no shift
		ctrl.shift_mag = shift_code[`TIA4_SHIFT_MAG_HI:`TIA4_SHIFT_LO]; // RULE8
		ctrl.shift_neg = shift_code[`TIA4_SHIFT_SIGN_BIT]
			&& (shift_code[`TIA4_SHIFT_MAG_HI:`TIA4_SHIFT_LO] != `TIA4_SHIFT_ZERO); // RULE8
	end

endmodule : tia4_decode

// >>> testbench/tia4_host_model.sv
// host side of the register port: one byte per strobe
module tia4_host_model (
	input  wire logic       core_clk_in,
	output logic            reg_wr_out,
	output logic            reg_rd_out,
	output logic [7:0]      reg_addr_out,
	output logic [7:0]      reg_wdata_out,
	input  wire logic [7:0] reg_rdata_in,
	input  wire logic       reg_rvalid_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle lines at time zero
	initial begin
		reg_wr_out    = 1'b0;
		reg_rd_out    = 1'b0;
		reg_addr_out  = 8'h00;
		reg_wdata_out = 8'h00;
	end

	// one write; the reserved gain code 01 is never sent
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk_in);
		reg_addr_out  = a;
		reg_wdata_out = d;
		reg_wr_out    = 1'b1;
		@(negedge core_clk_in);
		reg_wr_out    = 1'b0;
		reg_addr_out  = ~a; // released lines never keep the last value
		reg_wdata_out = ~d;
	endtask : wr

	// one read; answer is taken one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(negedge core_clk_in);
		reg_addr_out = a;
		reg_rd_out   = 1'b1;
		@(negedge core_clk_in);
		reg_rd_out   = 1'b0;
		reg_addr_out = ~a;
		ok           = reg_rvalid_in;
		d            = reg_rdata_in;
	endtask : rd

	// write and read in one cycle, then read again in the next cycle
	task automatic wrrd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q_old,
		output logic [7:0] q_new);
		@(negedge core_clk_in);
		reg_addr_out  = a;
		reg_wdata_out = d;
		reg_wr_out    = 1'b1;
		reg_rd_out    = 1'b1;
		@(negedge core_clk_in);
		reg_wr_out    = 1'b0;
		q_old         = reg_rdata_in;
		@(negedge core_clk_in);
		reg_rd_out    = 1'b0;
		reg_addr_out  = ~a;
		reg_wdata_out = ~d;
		q_new         = reg_rdata_in;
	endtask : wrrd

endmodule : tia4_host_model

// >>> testbench/tb_top.sv
module tb_top
	import tia4_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk_in, resetn_in, sel, sw, rt, gn, thp;
	logic wr, rd, rv, pwrdn, bo, grs, neg;
	logic [7:0] addr, wdata, rdata;
	logic [3:0] bw, swing;
	logic [2:0] mag;
	tia4_gain_t gain;
	int n_errors, compares, cycles;

	// clock and cycle ceiling
	initial begin
		core_clk_in = 1'b0;
		forever #4 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	tia4_host_model host (.core_clk_in(core_clk_in), .reg_wr_out(wr), .reg_rd_out(rd),
		.reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_rvalid_in(rv));

	tia4_regs dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_rvalid_out(rv), .two_wire_select_pad_in(sel), .swing_select_pad_in(sw),
		.rate_select_pad_in(rt), .gain_select_pad_in(gn), .threshold_select_pad_in(thp),
		.bw_trim_code_out(bw), .swing_code_out(swing), .power_down_out(pwrdn),
		.buffer_off_out(bo), .gain_step_out(gain), .gain_code_reserved_out(grs),
		.crosspoint_shift_mag_out(mag), .crosspoint_shift_neg_out(neg));

	// ----------------------------------------------------------------
	// compare helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask : rdchk

	// applied outputs follow two edges after a write, one edge after a pad change
	task automatic settle();
		repeat (2) @(negedge core_clk_in);
	endtask : settle

	// threshold/gain outputs against a byte, gain step apart
	task automatic thrchk(input logic [7:0] v, input tia4_gain_t g);
		chk({pwrdn, bo, neg, grs, 1'b0, mag}, {v[7], v[6], v[3] && (v[2:0] != 3'h0), 2'h0, v[2:0]});
		chk({5'h00, gain}, {5'h00, g});
	endtask : thrchk

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rdchk(8'h13, 8'h00);
		rdchk(8'h14, 8'h00);
		chk({bw, swing}, 8'h00);
		thrchk(8'h00, TIA4_GAIN_DEFAULT);
	endtask : t_reset

	task automatic t_swing();
		logic [7:0] tbl [4] = '{8'h06, 8'h76, 8'hf6, 8'h09};
		foreach (tbl[i]) begin
			host.wr(8'h13, tbl[i]);
			settle();
			chk({bw, swing}, tbl[i]);
			rdchk(8'h13, tbl[i]);
		end
	endtask : t_swing

	task automatic t_thr();
		logic [7:0] tbl [8] = '{8'h80, 8'h40, 8'h27, 8'h3f, 8'h08, 8'h01, 8'h09, 8'h00};
		tia4_gain_t g;
		foreach (tbl[i]) begin
			host.wr(8'h14, tbl[i]);
			settle();
			g = (tbl[i][5:4] == 2'h2) ? TIA4_GAIN_MEDIUM :
				(tbl[i][5:4] == 2'h3) ? TIA4_GAIN_MINIMUM : TIA4_GAIN_DEFAULT;
			thrchk(tbl[i], g);
			rdchk(8'h14, tbl[i]);
		end
	endtask : t_thr

	task automatic t_unmapped();
		host.wr(8'h15, 8'hff);
		rdchk(8'h15, 8'h00);
		rdchk(8'h14, 8'h00);
		rdchk(8'h13, 8'h09);
	endtask : t_unmapped

	// same-cycle write and read, then a read in the very next cycle
	task automatic t_b2b();
		logic [7:0] q_old;
		logic [7:0] q_new;
		host.wrrd(8'h13, 8'h5a, q_old, q_new);
		chk(q_old, 8'h09);
		chk(q_new, 8'h5a);
		settle();
		chk({bw, swing}, 8'h5a);
		host.wr(8'h13, 8'h09);
		rdchk(8'h13, 8'h09);
	endtask : t_b2b

	task automatic t_pads();
		host.wr(8'h14, 8'hc0);
		@(negedge core_clk_in);
		sel = 1'b0;
		settle();
		chk({bw, swing}, 8'hf6);
		thrchk(8'h01, TIA4_GAIN_MEDIUM);
		{sw, rt, gn, thp} = 4'h0;
		settle();
		chk({bw, swing}, 8'h03);
		thrchk(8'h00, TIA4_GAIN_DEFAULT);
		rdchk(8'h14, 8'hc0);
		sel = 1'b1;
		settle();
		thrchk(8'hc0, TIA4_GAIN_DEFAULT);
		chk({bw, swing}, 8'h09);
	endtask : t_pads

	task automatic give_verdict();
		$display("errors=%0d compares=%0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	// main sequence; pads held high so register mode must ignore them
	initial begin
		resetn_in = 1'b0;
		{sel, sw, rt, gn, thp} = 5'h1f;
		n_errors = 0;
		compares = 0;
		cycles = 0;
		repeat (20) @(negedge core_clk_in);
		resetn_in = 1'b1;
		t_reset();
		t_swing();
		t_thr();
		t_unmapped();
		t_b2b();
		t_pads();
		give_verdict();
	end

endmodule : tb_top
